// ==== verilog/egs_params.svh ====
// Command codes, reset values and field positions of the controller
`ifndef EGS_PARAMS_SVH
`define EGS_PARAMS_SVH
`define EGS_CMD_DRV 8'h01
`define EGS_CMD_SCAN 8'h0F
`define EGS_CMD_ENTRY 8'h11
`define EGS_CMD_WRBW 8'h24
`define EGS_CMD_WRRED 8'h26
`define EGS_CMD_RDRAM 8'h27
`define EGS_CMD_ENDOPT 8'h3F
`define EGS_CMD_RDOPT 8'h41
`define EGS_CMD_WINX 8'h44
`define EGS_CMD_WINY 8'h45
`define EGS_CMD_FRED 8'h46
`define EGS_CMD_FBW 8'h47
`define EGS_CMD_CNTX 8'h4E
`define EGS_CMD_CNTY 8'h4F
`define EGS_CMD_NOP 8'h7F
`define EGS_RST_LINES 9'h127
`define EGS_RST_ENTRY 3'h3
`define EGS_RST_ENDOPT 8'h02
`define EGS_RST_XEND 5'h15
`define EGS_RST_YEND 9'h127
`define EGS_END_KEEP 8'h07
`define EGS_AXIS_BIT 2
`define EGS_YDIR_BIT 1
`define EGS_XDIR_BIT 0
`define EGS_PAT_VAL_BIT 7
`define EGS_H_CODE_FULL 3'h6
`define EGS_H_CODE_BAD 3'h7
`define EGS_W_CODE_FULL 3'h5
`define EGS_ROWS 296
`define EGS_XBYTES 22
`endif

// ==== verilog/egs_pkg.sv ====
// Types shared by the serial receiver and the command interpreter
package egs_pkg;
  typedef enum logic [2:0] {
    EGS_IDLE = 3'b000,
    EGS_PARAM = 3'b001,
    EGS_WRITE = 3'b010,
    EGS_READ = 3'b011,
    EGS_FILL = 3'b100
  } egs_mode_t;
  typedef struct packed {
    logic valid;
    logic dc;
    logic [7:0] data;
  } egs_byte_t;
  typedef struct packed {
    logic we;
    logic re;
    logic plane;
    logic [4:0] x;
    logic [8:0] y;
    logic [7:0] data;
  } egs_ram_t;
  typedef struct packed {
    logic [8:0] gate_line_count;
    logic first_gate_select;
    logic interlace_select;
    logic scan_direction_select;
    logic [8:0] gate_start_row;
  } egs_gate_t;
  typedef struct packed {
    logic [1:0] sck_s;
    logic sck_d;
    logic [1:0] mosi_s;
    logic [1:0] cs_s;
    logic [1:0] dc_s;
    logic [2:0] cnt;
    logic [6:0] sh;
    egs_byte_t out;
  } egs_rx_st_t;
  typedef struct packed {
    egs_mode_t mode;
    logic [7:0] cmd;
    logic [2:0] idx;
    egs_gate_t gate;
    logic [2:0] entry;
    logic [7:0] endopt;
    logic hold;
    logic rdplane;
    logic [4:0] xs;
    logic [4:0] xe;
    logic [8:0] ys;
    logic [8:0] ye;
    logic [4:0] ax;
    logic [8:0] ay;
    logic val;
    logic [2:0] hcode;
    logic [2:0] wcode;
    egs_ram_t ram;
    logic busy;
    logic [8:0] row;
    logic active;
  } egs_core_st_t;
endpackage

// ==== verilog/egs_spi_rx.sv ====
// Serial byte receiver sampled by the core clock
`timescale 1ns/10ps
module egs_spi_rx
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic cs_n,
  input wire logic dc,
  output egs_pkg::egs_byte_t byte_o
);
  import egs_pkg::*;
  egs_rx_st_t s_r;
  egs_rx_st_t s_nxt;
  logic rise;

  ////////////////////////////////////////////////////////////////////
  // Two-stage synchronisers; only stage two feeds the logic
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.sck_s = {s_r.sck_s[0], sclk};
    s_nxt.sck_d = s_r.sck_s[1];
    s_nxt.mosi_s = {s_r.mosi_s[0], mosi};
    s_nxt.cs_s = {s_r.cs_s[0], cs_n};
    s_nxt.dc_s = {s_r.dc_s[0], dc};
    s_nxt.out.valid = 1'b0;
    rise = s_r.sck_s[1] & ~s_r.sck_d;
    // Deselect aborts a partial byte, so framing never slips
    if (s_r.cs_s[1])
    begin
      s_nxt.cnt = 3'h0;
    end
    else if (rise)
    begin
      s_nxt.sh = {s_r.sh[5:0], s_r.mosi_s[1]};
      s_nxt.cnt = s_r.cnt + 3'h1;
      if (s_r.cnt == 3'h7)
      begin
        s_nxt.out.valid = 1'b1;
        s_nxt.out.dc = s_r.dc_s[1];
        s_nxt.out.data = {s_r.sh, s_r.mosi_s[1]};
      end
    end
  end

  // Single register stage for all state
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign byte_o = s_r.out;
endmodule // egs_spi_rx

// ==== verilog/egs_core.sv ====
// Command interpreter: window, counters, pattern fill and gate scan map
// Functional notes
// [R1] End option byte: 22h normal, 07h holds source level before power off.
// [R2] Read-plane bit picks black/white plane (0) or red plane (1).
// [R3] X window start/end in 8-pixel units, reset 00h and 15h.
// [R4] Host sets window bounds before writing RAM data.
// [R5] Y window: 9-bit start and end, each low byte then bit 8.
// [R6] 46h fills red plane with pattern, seven height codes, busy high.
// [R7] 47h fills black/white plane; width codes 110, 111 invalid.
// [R8] 4Eh loads X address counter from one byte, reset zero.
// [R9] 4Fh loads 9-bit Y address counter, low byte first, reset zero.
// [R10] 7Fh changes nothing shown but ends RAM write or read.
// [R11] Driven gate lines equal line-count field plus one.
// [R12] Interlace 0 maps rows in order; 1 splits even and odd gates.
// [R13] First-gate bit swaps the rows of each adjacent gate pair.
// [R14] Scan-direction bit: 0 top to bottom, 1 bottom to top.
// [R15] 0Fh sets gate start row, offset added to scanned row.
// [R16] Counter steps after each write; direction bits per axis.
// [R17] Axis bit: 0 advances X first, 1 advances Y first.
// [R18] Successive writes stay inside the programmed window.
// [R19] Counter moves on writes only, never on reads.
// [R20] Host sets addresses inside the window, never in standby.
// [R21] At window end, reload start and step the other axis.
// [R22] Command bytes with select low, parameters with it high.
`timescale 1ns/10ps
`include "egs_params.svh"
module egs_core
#(
  parameter int ROWS = `EGS_ROWS,
  parameter int XBYTES = `EGS_XBYTES
)
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic spi_sclk,
  input wire logic spi_mosi,
  input wire logic spi_cs_n,
  input wire logic spi_dc,
  input wire logic [8:0] scan_gate,
  output egs_pkg::egs_ram_t ram_o,
  output egs_pkg::egs_gate_t gate_cfg_o,
  output logic [8:0] scan_row_o,
  output logic gate_active_o,
  output logic busy_o,
  output logic read_plane_o,
  output logic [7:0] waveform_end_choice_o,
  output logic source_hold_o
);
  import egs_pkg::*;

  egs_core_st_t s_r;
  egs_core_st_t s_nxt;
  egs_byte_t rx;

  generate
    if (ROWS < 16 || ROWS > 512 || XBYTES < 1 || XBYTES > 32)
    begin : g_bad_size
      $error("egs_core: ROWS or XBYTES out of range");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////
  // Serial link front end
  egs_spi_rx u_rx
  (
    .clk(clk),
    .reset_n(reset_n),
    .sclk(spi_sclk),
    .mosi(spi_mosi),
    .cs_n(spi_cs_n),
    .dc(spi_dc),
    .byte_o(rx)
  );

  ////////////////////////////////////////////////////////////////////
  // One address step, up or down; wraps modulo the field width
  function automatic logic [8:0] step9(input logic [8:0] v,
                                      input logic inc);
    step9 = inc ? v + 9'h001 : v - 9'h001;
  endfunction

  // Pattern byte: start value flipped per height and width block
  function automatic logic [7:0] fill_byte(input logic v,
    input logic [2:0] h, input logic [2:0] w,
    input logic [4:0] x, input logic [8:0] y);
    logic [8:0] ty;
    logic [4:0] tx;
    logic p;
    ty = y >> (4'(h) + 4'h3);
    tx = x >> w;
    p = v;
    if (h != `EGS_H_CODE_FULL)
      p = p ^ ty[0];
    if (w != `EGS_W_CODE_FULL)
      p = p ^ tx[0];
    fill_byte = {8{p}};
  endfunction

  // Gate index to RAM row under the scan settings
  function automatic logic [8:0] map_row(input logic [8:0] g,
                                        input egs_gate_t c);
    logic [9:0] n;
    logic [8:0] g1;
    logic [8:0] r;
    logic [9:0] t;
    n = {1'b0, c.gate_line_count} + 10'h001;
    g1 = c.scan_direction_select ? c.gate_line_count - g : g; // R14
    if (c.first_gate_select)
      g1 = g1 ^ 9'h001; // R13
    r = g1;
    if (c.interlace_select) // R12
      r = g1[0] ? 9'(n >> 1) + (g1 >> 1) : (g1 >> 1);
    // Start row rotates the picture, wrapping at the line count;
    // a full modulo, since the start row may exceed the line count
    t = {1'b0, r} + {1'b0, c.gate_start_row}; // R15
    map_row = 9'(t % n);
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Next-state logic for all interpreter state
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.ram.we = 1'b0;
    s_nxt.ram.re = 1'b0;
    s_nxt.row = map_row(scan_gate, s_r.gate);
    s_nxt.active = scan_gate <= s_r.gate.gate_line_count; // R11
    if (s_r.mode == EGS_FILL)
    begin
      // Link bytes are dropped while busy; host must wait for it
      if (s_r.ram.x == 5'(XBYTES - 1) && s_r.ram.y == 9'(ROWS - 1))
      begin
        s_nxt.mode = EGS_IDLE;
        s_nxt.busy = 1'b0;
      end
      else
      begin
        s_nxt.ram.we = 1'b1; // R6 R7
        if (s_r.ram.x == 5'(XBYTES - 1))
        begin
          s_nxt.ram.x = 5'h00;
          s_nxt.ram.y = s_r.ram.y + 9'h001;
        end
        else
          s_nxt.ram.x = s_r.ram.x + 5'h01;
        s_nxt.ram.data = fill_byte(s_r.val, s_r.hcode, s_r.wcode,
                                   s_nxt.ram.x, s_nxt.ram.y);
      end
    end
    else if (rx.valid && !rx.dc) // R22
    begin
      // Any new command closes a running RAM access
      s_nxt.cmd = rx.data;
      s_nxt.idx = 3'h0;
      case (rx.data)
        `EGS_CMD_WRBW, `EGS_CMD_WRRED:
        begin
          s_nxt.mode = EGS_WRITE;
          s_nxt.ram.plane = rx.data == `EGS_CMD_WRRED;
        end
        `EGS_CMD_RDRAM:
        begin
          s_nxt.mode = EGS_READ;
          s_nxt.ram.plane = s_r.rdplane; // R2
        end
        `EGS_CMD_NOP:
          s_nxt.mode = EGS_IDLE; // R10
        default:
          s_nxt.mode = EGS_PARAM;
      endcase
    end
    else if (rx.valid) // R22
    begin
      case (s_r.mode)
        EGS_WRITE:
        begin
          s_nxt.ram.we = 1'b1;
          s_nxt.ram.x = s_r.ax;
          s_nxt.ram.y = s_r.ay;
          s_nxt.ram.data = rx.data;
          // Advance, reloading at the window end
          if (!s_r.entry[`EGS_AXIS_BIT]) // R17
          begin
            if (s_r.ax == s_r.xe) // R18 R21
            begin
              s_nxt.ax = s_r.xs;
              s_nxt.ay = (s_r.ay == s_r.ye) ? s_r.ys :
                step9(s_r.ay, s_r.entry[`EGS_YDIR_BIT]);
            end
            else // R16
              s_nxt.ax = 5'(step9({4'h0, s_r.ax},
                                  s_r.entry[`EGS_XDIR_BIT]));
          end
          else
          begin
            if (s_r.ay == s_r.ye) // R18 R21
            begin
              s_nxt.ay = s_r.ys;
              s_nxt.ax = (s_r.ax == s_r.xe) ? s_r.xs :
                5'(step9({4'h0, s_r.ax}, s_r.entry[`EGS_XDIR_BIT]));
            end
            else // R16
              s_nxt.ay = step9(s_r.ay, s_r.entry[`EGS_YDIR_BIT]);
          end
        end
        EGS_READ:
        begin
          // Counter left alone on reads
          s_nxt.ram.re = 1'b1; // R19
          s_nxt.ram.x = s_r.ax;
          s_nxt.ram.y = s_r.ay;
        end
        EGS_PARAM:
        begin
          s_nxt.idx = (s_r.idx == 3'h7) ? s_r.idx : s_r.idx + 3'h1;
          case (s_r.cmd)
            `EGS_CMD_DRV:
            begin
              if (s_r.idx == 3'h0)
                s_nxt.gate.gate_line_count[7:0] = rx.data; // R11
              if (s_r.idx == 3'h1)
                s_nxt.gate.gate_line_count[8] = rx.data[0];
              if (s_r.idx == 3'h2)
              begin
                s_nxt.gate.first_gate_select = rx.data[2]; // R13
                s_nxt.gate.interlace_select = rx.data[1]; // R12
                s_nxt.gate.scan_direction_select = rx.data[0]; // R14
              end
            end
            `EGS_CMD_SCAN:
            begin
              if (s_r.idx == 3'h0)
                s_nxt.gate.gate_start_row[7:0] = rx.data; // R15
              if (s_r.idx == 3'h1)
                s_nxt.gate.gate_start_row[8] = rx.data[0];
            end
            `EGS_CMD_ENTRY:
              if (s_r.idx == 3'h0)
                s_nxt.entry = rx.data[2:0]; // R16 R17
            `EGS_CMD_ENDOPT:
              if (s_r.idx == 3'h0)
              begin
                s_nxt.endopt = rx.data; // R1
                s_nxt.hold = rx.data == `EGS_END_KEEP;
              end
            `EGS_CMD_RDOPT:
              if (s_r.idx == 3'h0)
                s_nxt.rdplane = rx.data[0]; // R2
            `EGS_CMD_WINX:
            begin
              if (s_r.idx == 3'h0)
                s_nxt.xs = rx.data[4:0]; // R3
              if (s_r.idx == 3'h1)
                s_nxt.xe = rx.data[4:0];
            end
            `EGS_CMD_WINY:
            begin
              if (s_r.idx == 3'h0)
                s_nxt.ys[7:0] = rx.data; // R5
              if (s_r.idx == 3'h1)
                s_nxt.ys[8] = rx.data[0];
              if (s_r.idx == 3'h2)
                s_nxt.ye[7:0] = rx.data;
              if (s_r.idx == 3'h3)
                s_nxt.ye[8] = rx.data[0];
            end
            `EGS_CMD_FRED, `EGS_CMD_FBW:
              // Invalid size codes leave the planes untouched
              if (s_r.idx == 3'h0 && rx.data[6:4] != `EGS_H_CODE_BAD
                  && rx.data[2:0] <= `EGS_W_CODE_FULL) // R6 R7
              begin
                s_nxt.mode = EGS_FILL;
                s_nxt.busy = 1'b1;
                s_nxt.val = rx.data[`EGS_PAT_VAL_BIT];
                s_nxt.hcode = rx.data[6:4];
                s_nxt.wcode = rx.data[2:0];
                s_nxt.ram.we = 1'b1;
                s_nxt.ram.plane = s_r.cmd == `EGS_CMD_FRED;
                s_nxt.ram.x = 5'h00;
                s_nxt.ram.y = 9'h000;
                s_nxt.ram.data = fill_byte(rx.data[`EGS_PAT_VAL_BIT],
                  rx.data[6:4], rx.data[2:0], 5'h00, 9'h000);
              end
            `EGS_CMD_CNTX:
              if (s_r.idx == 3'h0)
                s_nxt.ax = rx.data[4:0]; // R8
            `EGS_CMD_CNTY:
            begin
              if (s_r.idx == 3'h0)
                s_nxt.ay[7:0] = rx.data; // R9
              if (s_r.idx == 3'h1)
                s_nxt.ay[8] = rx.data[0];
            end
            default:
            begin
            end
          endcase
        end
        default:
        begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // State register with power-on values
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s_r <= '0;
      s_r.gate.gate_line_count <= `EGS_RST_LINES;
      s_r.entry <= `EGS_RST_ENTRY;
      s_r.endopt <= `EGS_RST_ENDOPT;
      s_r.xe <= `EGS_RST_XEND; // R3
      s_r.ye <= `EGS_RST_YEND;
    end
    else
      s_r <= s_nxt;
  end

  // Outputs straight from the state register
  assign ram_o = s_r.ram;
  assign gate_cfg_o = s_r.gate;
  assign scan_row_o = s_r.row;
  assign gate_active_o = s_r.active;
  assign busy_o = s_r.busy;
  assign read_plane_o = s_r.rdplane;
  assign waveform_end_choice_o = s_r.endopt;
  assign source_hold_o = s_r.hold;

  ////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  logic wr_hit;
  assign wr_hit = rx.valid && rx.dc && s_r.mode == EGS_WRITE;

  property p_fill_busy;
    s_r.mode == EGS_FILL |-> s_r.busy && busy_o;
  endproperty
  a_fill_busy: assert property (p_fill_busy) // R6
    else $error("busy low during fill");

  property p_fill_we;
    s_r.mode == EGS_FILL && s_nxt.mode == EGS_FILL |=> ram_o.we;
  endproperty
  a_fill_we: assert property (p_fill_we) // R7
    else $error("fill stopped writing");

  property p_cntx_load;
    rx.valid && rx.dc && s_r.mode == EGS_PARAM
      && s_r.cmd == `EGS_CMD_CNTX && s_r.idx == 3'h0
      |=> s_r.ax == $past(rx.data[4:0]);
  endproperty
  a_cntx_load: assert property (p_cntx_load) // R8
    else $error("X counter not loaded");

  property p_read_hold;
    ram_o.re |-> s_r.ax == $past(s_r.ax) && s_r.ay == $past(s_r.ay);
  endproperty
  a_read_hold: assert property (p_read_hold) // R19
    else $error("counter moved on read");

  property p_step_x;
    wr_hit && !s_r.entry[2] && s_r.entry[0] && s_r.ax != s_r.xe
      |=> s_r.ax == $past(s_r.ax) + 5'h01;
  endproperty
  a_step_x: assert property (p_step_x) // R16
    else $error("X counter did not increment");

  property p_wrap_x;
    wr_hit && !s_r.entry[2] && s_r.ax == s_r.xe
      |=> s_r.ax == $past(s_r.xs) && ram_o.x == $past(s_r.xe);
  endproperty
  a_wrap_x: assert property (p_wrap_x) // R21
    else $error("X counter did not reload at window end");

  property p_nop_idle;
    rx.valid && !rx.dc && rx.data == `EGS_CMD_NOP
      && s_r.mode != EGS_FILL
      |=> s_r.mode == EGS_IDLE ##1 !ram_o.we;
  endproperty
  a_nop_idle: assert property (p_nop_idle) // R10
    else $error("no-op left RAM access open");

  property p_rdplane;
    rx.valid && !rx.dc && rx.data == `EGS_CMD_RDRAM
      && s_r.mode != EGS_FILL
      |=> ram_o.plane == read_plane_o;
  endproperty
  a_rdplane: assert property (p_rdplane) // R2
    else $error("read plane mismatch");

  c_fill: cover property ($rose(busy_o) ##[1:20] ram_o.we);
  c_wrap: cover property (wr_hit && s_r.ax == s_r.xe);
  c_read: cover property (ram_o.re);
  c_nop: cover property (rx.valid && !rx.dc
                         && rx.data == `EGS_CMD_NOP);
endmodule // egs_core

// ==== bench/egs_host.sv ====
// Host controller model driving the serial command link
`timescale 1ns/10ps
module egs_host
(
  output logic sclk,
  output logic mosi,
  output logic cs_n,
  output logic dc
);
  ////////////////////////////////////////////////////////////////////////
  // Idle link: clock low, deselected
  initial
  begin
    sclk = 1'b0;
    mosi = 1'b1;
    cs_n = 1'b1;
    dc = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////
  // One framed byte, MSB first, 400 ns link period
  task automatic send(input logic cmd, input logic [7:0] b);
    #7 cs_n = 1'b0;
    dc = ~cmd;
    for (int i = 7; i >= 0; i--)
    begin
      mosi = b[i];
      #200 sclk = 1'b1;
      #200 sclk = 1'b0;
    end
    #200 cs_n = 1'b1;
    // Released data line must not keep its last level
    mosi = ~mosi;
    #200;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Command then its parameters, low byte first
  task automatic cmd(input logic [7:0] c, input int n, input logic [31:0] p);
    send(1'b1, c);
    for (int i = 0; i < n; i++)
      send(1'b0, p[8*i +: 8]);
  endtask
endmodule // egs_host

// ==== bench/tb_top.sv ====
// Self-checking bench for the command interpreter
`timescale 1ns/10ps
module tb_top;
  import egs_pkg::*;
  typedef struct packed {
    logic [7:0] c;
    logic [7:0] n;
    logic [31:0] p;
    logic [20:0] g;
    logic [9:0] o;
  } egs_row_t;
  localparam int ROWS = 16;
  localparam int XB = 2;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [8:0] scan_gate = 9'h000;
  logic sclk, mosi, cs_n, dc;
  egs_ram_t ram_o;
  egs_gate_t gate_cfg_o;
  logic [8:0] scan_row_o;
  logic gate_active_o, busy_o, read_plane_o, source_hold_o;
  logic [7:0] end_o;
  int fail_count = 0;
  int checks = 0;
  int bcnt = 0;
  egs_ram_t seen_q[$];
  egs_row_t rows[6] = '{
    '{8'h3F, 8'h01, 32'h22, {9'h127, 12'h000}, {2'b00, 8'h22}},
    '{8'h3F, 8'h01, 32'h07, {9'h127, 12'h000}, {2'b01, 8'h07}},
    '{8'h41, 8'h01, 32'h01, {9'h127, 12'h000}, {2'b11, 8'h07}},
    '{8'h01, 8'h03, 32'h07000F, {9'h00F, 12'hE00}, {2'b11, 8'h07}},
    '{8'h0F, 8'h02, 32'h0125, {9'h00F, 12'hF25}, {2'b11, 8'h07}},
    '{8'h7F, 8'h00, 32'h0, {9'h00F, 12'hF25}, {2'b11, 8'h07}}
  };

  always #25 clk = ~clk;

  egs_host u_egs_host (.sclk(sclk), .mosi(mosi), .cs_n(cs_n), .dc(dc));

  egs_core #(.ROWS(ROWS), .XBYTES(XB)) u_egs_core
  (
    .clk(clk),
    .reset_n(reset_n),
    .spi_sclk(sclk),
    .spi_mosi(mosi),
    .spi_cs_n(cs_n),
    .spi_dc(dc),
    .scan_gate(scan_gate),
    .ram_o(ram_o),
    .gate_cfg_o(gate_cfg_o),
    .scan_row_o(scan_row_o),
    .gate_active_o(gate_active_o),
    .busy_o(busy_o),
    .read_plane_o(read_plane_o),
    .waveform_end_choice_o(end_o),
    .source_hold_o(source_hold_o)
  );

  ////////////////////////////////////////////////////////////////////////
  // Capture every RAM strobe and count busy cycles
  always @(posedge clk)
  begin
    if (ram_o.we || ram_o.re)
      seen_q.push_back(ram_o);
    if (busy_o === 1'b1)
      bcnt++;
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e)
    begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  // Missing strobes compare as all zero
  task automatic pop(input logic [24:0] e, input logic [24:0] m = '1);
    egs_ram_t s;
    s = '0;
    if (seen_q.size() > 0)
      s = seen_q.pop_front();
    chk({7'h00, s & m}, {7'h00, e});
  endtask

  // Independent gate map: direction, pair swap, split, start offset
  function automatic logic [8:0] gmap(input logic [8:0] g, input egs_gate_t c);
    logic [9:0] r;
    logic [9:0] n;
    n = {1'b0, c.gate_line_count} + 10'h001;
    r = c.scan_direction_select ? n - 10'h001 - {1'b0, g} : {1'b0, g};
    r[0] = r[0] ^ c.first_gate_select;
    if (c.interlace_select)
      r = r[0] ? (n >> 1) + (r >> 1) : r >> 1;
    r = (r + {1'b0, c.gate_start_row}) % n;
    return r[8:0];
  endfunction

  // Fill pattern: start value, flipped per height and width step
  function automatic logic pat(input logic [7:0] p, input int k);
    int y;
    int x;
    logic r;
    y = k / XB;
    x = k % XB;
    r = p[7];
    if (p[6:4] != 3'h6)
      r = r ^ y[p[6:4] + 3];
    if (p[2:0] != 3'h5)
      r = r ^ x[p[2:0]];
    return r;
  endfunction

  task automatic sweep(input egs_gate_t c);
    for (int g = 0; g < 20; g++)
    begin
      @(posedge clk);
      scan_gate <= 9'(g);
      @(posedge clk);
      @(negedge clk);
      chk({31'h0, gate_active_o}, {31'h0, 9'(g) <= c.gate_line_count});
      if (9'(g) <= c.gate_line_count)
        chk({23'h0, scan_row_o}, {23'h0, gmap(9'(g), c)});
    end
  endtask

  task automatic fill(input logic [7:0] p, input int nw, input logic pl);
    bcnt = 0;
    u_egs_host.cmd(8'h46 + {7'h00, ~pl}, 1, {24'h0, p});
    for (int i = 0; i < 4000 && busy_o !== 1'b0; i++)
      @(posedge clk);
    chk(32'(bcnt), 32'(nw));
    for (int k = 0; k < nw; k++)
      pop({2'b10, pl, 5'(k % XB), 9'(k / XB), {8{pat(p, k)}}});
    chk(32'(seen_q.size()), 32'h0);
  endtask

  task automatic end_sim;
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    #3ms;
    fail_count++;
    end_sim;
  end

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    chk({11'h0, gate_cfg_o}, {11'h0, 9'h127, 12'h000});
    chk({22'h0, read_plane_o, source_hold_o, end_o}, 32'h02);
    chk({6'h0, busy_o, ram_o}, 32'h0);
    for (int i = 0; i < 6; i++)
    begin
      u_egs_host.cmd(rows[i].c, int'(rows[i].n), rows[i].p);
      chk({11'h0, gate_cfg_o}, {11'h0, rows[i].g});
      chk({22'h0, read_plane_o, source_hold_o, end_o}, {22'h0, rows[i].o});
    end
    sweep(rows[5].g);
    u_egs_host.cmd(8'h01, 3, 32'h00000F);
    u_egs_host.cmd(8'h0F, 2, 32'h0003);
    sweep({9'h00F, 3'h0, 9'h003});
    // X fast, Y decrementing, window X 1..2 Y 5..3
    u_egs_host.cmd(8'h44, 2, 32'h0201);
    u_egs_host.cmd(8'h45, 4, 32'h00030005);
    u_egs_host.cmd(8'h11, 1, 32'h01);
    u_egs_host.cmd(8'h4E, 1, 32'h01);
    u_egs_host.cmd(8'h4F, 2, 32'h0005);
    u_egs_host.cmd(8'h24, 0, 32'h0);
    for (int k = 0; k < 7; k++)
      u_egs_host.send(1'b0, 8'(k));
    for (int k = 0; k < 7; k++)
      pop({3'b100, 5'(1 + k % 2), 9'(5 - (k / 2) % 3), 8'(k)});
    // Y fast, X decrementing, red plane
    u_egs_host.cmd(8'h44, 2, 32'h0102);
    u_egs_host.cmd(8'h45, 4, 32'h00040003);
    u_egs_host.cmd(8'h11, 1, 32'h06);
    u_egs_host.cmd(8'h4E, 1, 32'h02);
    u_egs_host.cmd(8'h4F, 2, 32'h0003);
    u_egs_host.cmd(8'h26, 0, 32'h0);
    for (int k = 0; k < 5; k++)
      u_egs_host.send(1'b0, 8'(k));
    for (int k = 0; k < 5; k++)
      pop({3'b101, 5'(2 - (k / 2) % 2), 9'(3 + k % 2), 8'(k)});
    // No-op closes the write; reads leave the counter alone
    u_egs_host.cmd(8'h7F, 0, 32'h0);
    u_egs_host.send(1'b0, 8'hAA);
    chk(32'(seen_q.size()), 32'h0);
    u_egs_host.cmd(8'h27, 0, 32'h0);
    u_egs_host.send(1'b0, 8'h11);
    u_egs_host.send(1'b0, 8'h22);
    pop({3'b011, 5'd2, 9'd4, 8'h00}, {17'h1FFFF, 8'h00});
    pop({3'b011, 5'd2, 9'd4, 8'h00}, {17'h1FFFF, 8'h00});
    u_egs_host.cmd(8'h24, 0, 32'h0);
    u_egs_host.send(1'b0, 8'h5A);
    pop({3'b100, 5'd2, 9'd4, 8'h5A});
    fill(8'h80, ROWS * XB, 1'b1);
    fill(8'h06, 0, 1'b0);
    fill(8'h70, 0, 1'b1);
    fill(8'h15, ROWS * XB, 1'b0);
    // Second reset in mid-run restores defaults
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    chk({22'h0, read_plane_o, source_hold_o, end_o}, 32'h02);
    chk({11'h0, gate_cfg_o}, {11'h0, 9'h127, 12'h000});
    u_egs_host.cmd(8'h24, 0, 32'h0);
    u_egs_host.send(1'b0, 8'h01);
    u_egs_host.send(1'b0, 8'h02);
    pop({3'b100, 5'd0, 9'd0, 8'h01});
    pop({3'b100, 5'd1, 9'd0, 8'h02});
    end_sim;
  end
endmodule // tb_top
